//--- common/acp_params.svh
// Constants of the converter configuration port: bit positions, reset value, timing
`ifndef ACP_PARAMS_SVH
`define ACP_PARAMS_SVH

`define ACP_WORD_W 9
`define ACP_START_BIT 8
`define ACP_BIPOLAR_BIT 7
`define ACP_TEN_BIT 6
`define ACP_PD_BIT 5
`define ACP_IMPULSE_BIT 4
`define ACP_WARP_BIT 3
`define ACP_CODING_BIT 2
`define ACP_RSV_MSB 1
`define ACP_CFG_RESET 9'h000
`define ACP_LOAD_BITS 8
`define ACP_CLK_MHZ 50
`define ACP_ACQ_TIME_NS 250
`define ACP_ACQ_CYCLES ((`ACP_ACQ_TIME_NS * `ACP_CLK_MHZ + 999) / 1000)

`endif

//--- common/acp_pkg.sv
// Types of the converter configuration port
`default_nettype none
package acp_pkg;

  typedef enum logic [1:0] {
    ACP_RANGE_0_5,
    ACP_RANGE_0_10,
    ACP_RANGE_PM5,
    ACP_RANGE_PM10
  } acp_range_e;

  typedef enum logic [1:0] {
    ACP_MODE_NORMAL,
    ACP_MODE_IMPULSE,
    ACP_MODE_WARP
  } acp_mode_e;

  typedef enum logic {
    ACP_SHIFT_WAIT_START,
    ACP_SHIFT_LOAD
  } acp_shift_e;

  typedef logic [8:0] acp_word_t;

endpackage
`default_nettype wire

//--- common/acp_word_if.sv
// Word and completion toggle passed from the serial port domain to the core
`timescale 1ns/1ns
`default_nettype none
interface acp_word_if;
  import acp_pkg::*;
  acp_word_t word;
  logic done_tgl;
  modport src (output word, output done_tgl);
  modport dst (input word, input done_tgl);
endinterface
`default_nettype wire

//--- dv/acp_checker.sv
// Assertions on the configuration port pins
`timescale 1ns/1ns
`default_nettype none
module acp_checker #(
  parameter int ACQ_CYCLES = 13
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic serial_parallel_select,
  input wire logic hardware_software_select,
  input wire logic pin_warp,
  input wire logic pin_impulse,
  input wire logic pin_bipolar,
  input wire logic wide_range_select,
  input wire logic output_coding_select,
  input wire logic power_down,
  input wire logic [1:0] range_select,
  input wire logic [1:0] conv_mode,
  input wire logic converter_powered_down,
  input wire logic straight_binary,
  input wire logic software_config,
  input wire logic config_port_enable,
  input wire acp_pkg::acp_word_t config_word,
  input wire logic config_update,
  input wire logic config_settling
);
  import acp_pkg::*;
  int unsigned run_r;
  logic sw;
  logic [5:0] outs, pins, wd;
  assign sw = serial_parallel_select && !hardware_software_select;
  assign outs = {range_select, conv_mode, converter_powered_down, straight_binary};
  // Both mode bits high read as normal
  assign pins = {pin_bipolar, wide_range_select, (pin_impulse ^ pin_warp) ?
    {pin_warp, pin_impulse} : 2'b00, power_down, output_coding_select};
  assign wd = {config_word[7:6], (config_word[4] ^ config_word[3]) ?
    {config_word[3], config_word[4]} : 2'b00, config_word[5], config_word[2]};
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) run_r <= 0;
    else run_r <= config_settling ? run_r + 1 : 0;
  end
  sequence sw_held;
    sw[*8];
  endsequence
  sequence hw_held;
    (!sw && $stable(pins))[*8];
  endsequence
  sequence sw_quiet;
    (software_config && !config_update)[*3];
  endsequence
  sequence hw_sel;
    (!sw)[*8];
  endsequence
  update_pulse_a: assert property (config_update |=> !config_update)
    else $error("update pulse too long");
  rsv_zero_a: assert property (config_word[1:0] == 2'b00)
    else $error("reserved bits set");
  enable_match_a: assert property (sw_held |-> config_port_enable)
    else $error("port enable missed");
  port_off_a: assert property (hw_sel |-> !(config_port_enable || software_config))
    else $error("port enabled in hardware mode");
  sw_select_a: assert property (sw_held |-> software_config)
    else $error("software mode missed");
  hw_map_a: assert property (hw_held |-> outs == pins)
    else $error("pin settings not applied");
  sw_hold_a: assert property (sw_quiet |=> $stable(outs))
    else $error("settings moved");
  word_apply_a: assert property (config_update |-> ##2 outs == wd)
    else $error("word not applied");
  settle_len_a: assert property ($fell(config_settling) |-> run_r >= ACQ_CYCLES)
    else $error("settling too short");
endmodule // acp_checker
`default_nettype wire

//--- dv/acp_host.sv
// Host controller model writing the serial configuration port
`timescale 1ns/1ns
`default_nettype none
module acp_host (
  input wire logic inv,
  output wire logic sclk,
  output logic cs_n,
  output logic sdi
);
  logic ph = 1'b0;
  // Idle clock rests at the strap level, so no stray active edge
  assign sclk = ph ^ inv;
  initial begin
    cs_n = 1'b1;
    sdi = 1'b1;
  end
  // No conversion runs in this bench, so no write lands late in busy
  task automatic send(input logic [8:0] w, input int n);
    cs_n = 1'b0;
    #15;
    for (int i = 8; i > 8 - n; i--) begin
      sdi = w[i];
      #15 ph = 1'b1;
      #15 ph = 1'b0;
    end
    #15 cs_n = 1'b1;
    // Released line must not keep the last bit
    sdi = ~sdi;
  endtask
endmodule // acp_host
`default_nettype wire

//--- dv/adc_config_port_tb.sv
// Self-checking bench for the converter configuration port
`timescale 1ns/1ns
`default_nettype none
module adc_config_port_tb;
  logic clk = 1'b0, rst_b = 1'b0, serial_clock_invert = 1'b0;
  logic serial_parallel_select = 1'b1, hardware_software_select = 1'b0;
  logic pin_warp = 1'b0, pin_impulse = 1'b0, pin_bipolar = 1'b0, power_down = 1'b0;
  logic wide_range_select = 1'b0, output_coding_select = 1'b0;
  wire logic config_serial_clock, config_port_select_n, config_serial_data_in;
  logic [1:0] range_select, conv_mode;
  logic [8:0] config_word, last = 9'h000;
  logic converter_powered_down, straight_binary, software_config, config_port_enable;
  logic config_update, config_settling;
  int mismatches = 0, samples_checked = 0, upd_cnt = 0, cyc = 0;
  logic [8:0] words [4] = '{9'h1ff, 9'h15b, 9'h193, 9'h10f};
  wire logic [5:0] outs = {range_select, conv_mode, converter_powered_down, straight_binary};
  acp_config_port dut (.*);
  acp_host host (.inv(serial_clock_invert), .sclk(config_serial_clock),
    .cs_n(config_port_select_n), .sdi(config_serial_data_in));
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    if (mismatches == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk_set(input logic [8:0] w);
    logic [1:0] md;
    md = (w[4] ^ w[3]) ? {w[3], w[4]} : 2'b00;
    chk({3'h0, outs}, {3'h0, w[7:6], md, w[5], w[2]});
  endtask
  task automatic sw_write(input logic [8:0] w, input int n, input int e);
    int c0;
    logic sw_exp;
    c0 = upd_cnt;
    sw_exp = serial_parallel_select & ~hardware_software_select;
    host.send(w, n);
    // Sync path is over, the acquisition time is still running
    repeat (10) @(negedge clk);
    chk(9'(upd_cnt - c0), 9'(e));
    chk({7'h0, software_config, config_port_enable}, {7'h0, sw_exp, sw_exp});
    if (e == 1) begin
      last = w;
      chk(config_word, {w[8:2], 2'b00});
      chk({8'h00, config_settling}, 9'h001);
    end
    chk_set(last);
  endtask
  initial forever #10 clk = ~clk;
  // Counted mid-cycle so the one-cycle pulse is seen once, settled
  always @(negedge clk) begin
    cyc++;
    if (config_update === 1'b1) upd_cnt++;
    if (cyc == 3000) begin
      mismatches++;
      stop_test();
    end
  end
  initial begin
    repeat (10) @(negedge clk);
    rst_b = 1'b1;
    // Pins all high, yet the serial register owns the settings
    {pin_bipolar, wide_range_select, power_down, pin_impulse, pin_warp} = 5'h1f;
    output_coding_select = 1'b1;
    repeat (10) @(negedge clk);
    chk_set(9'h000);
    chk(config_word, 9'h000);
    for (int v = 0; v < 2; v++) begin
      serial_clock_invert = v[0];
      foreach (words[i]) sw_write(words[i], 9, 1);
    end
    sw_write(9'h1ff, 5, 0);
    sw_write(9'h0ff, 9, 0);
    sw_write(9'h193, 9, 1);
    hardware_software_select = 1'b1;
    for (int k = 0; k < 8; k++) begin
      serial_parallel_select = k[2];
      {pin_bipolar, wide_range_select, power_down} = {k[1], k[0], k[0]};
      {pin_impulse, pin_warp, output_coding_select} = {k[0], k[1], k[1]};
      last = {1'b1, k[1], k[0], k[0], k[0], k[1], k[1], 2'b00};
      sw_write(9'h1ff, 9, 0);
    end
    {serial_parallel_select, hardware_software_select} = 2'b10;
    last = 9'h193;
    sw_write(9'h1ff, 4, 0);
    // Pins move while software mode owns the settings
    {pin_bipolar, wide_range_select, power_down, pin_impulse, pin_warp} = 5'h0a;
    output_coding_select = 1'b0;
    sw_write(9'h1ff, 3, 0);
    repeat (5) @(negedge clk);
    chk({8'h00, config_settling}, 9'h000);
    // Second reset in mid-run must clear a loaded word
    rst_b = 1'b0;
    repeat (3) @(negedge clk);
    rst_b = 1'b1;
    repeat (10) @(negedge clk);
    chk(config_word, 9'h000);
    chk_set(9'h000);
    sw_write(9'h15b, 9, 1);
    stop_test();
  end
endmodule // adc_config_port_tb
bind acp_config_port acp_checker #(.ACQ_CYCLES(ACQ_CYCLES)) mon (.*);
`default_nettype wire

//--- logic/acp_config_port.sv
// Configuration core of the converter: pin and serial-port settings
`timescale 1ns/1ns
`default_nettype none
`include "acp_params.svh"
module acp_config_port #(
  parameter int ACQ_CYCLES = `ACP_ACQ_CYCLES
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic serial_parallel_select,
  input wire logic hardware_software_select,
  input wire logic pin_warp,
  input wire logic pin_impulse,
  input wire logic pin_bipolar,
  input wire logic wide_range_select,
  input wire logic output_coding_select,
  input wire logic power_down,
  input wire logic config_serial_clock,
  input wire logic config_port_select_n,
  input wire logic config_serial_data_in,
  input wire logic serial_clock_invert,
  output acp_pkg::acp_range_e range_select,
  output acp_pkg::acp_mode_e conv_mode,
  output logic converter_powered_down,
  output logic straight_binary,
  output logic software_config,
  output logic config_port_enable,
  output acp_pkg::acp_word_t config_word,
  output logic config_update,
  output logic config_settling
);
  import acp_pkg::*;

  localparam int CNT_W = $clog2(ACQ_CYCLES + 1);

  // Reset release
  logic rst_s1_r;
  logic rst_n_r;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r <= rst_s1_r;
    end
  end

  // Pin synchronisers: ser, hw, then six setting pins
  logic [7:0] pin_raw;
  logic [7:0] pin_s1_r;
  logic [7:0] pin_s2_r;

  assign pin_raw = {serial_parallel_select,
                    hardware_software_select,
                    pin_bipolar,
                    wide_range_select,
                    power_down,
                    pin_impulse,
                    pin_warp,
                    output_coding_select};

  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      pin_s1_r <= 8'h00;
      pin_s2_r <= 8'h00;
    end else begin
      pin_s1_r <= pin_raw;
      pin_s2_r <= pin_s1_r;
    end
  end

  logic ser_s;
  logic hw_s;
  logic [8:0] pin_word;
  logic sw_mode;

  assign ser_s = pin_s2_r[7];
  assign hw_s = pin_s2_r[6];

  // Pins laid out in configuration-word order for a common decode
  always_comb begin
    pin_word = `ACP_CFG_RESET;
    pin_word[`ACP_BIPOLAR_BIT] = pin_s2_r[5];
    pin_word[`ACP_TEN_BIT] = pin_s2_r[4];
    pin_word[`ACP_PD_BIT] = pin_s2_r[3];
    pin_word[`ACP_IMPULSE_BIT] = pin_s2_r[2];
    pin_word[`ACP_WARP_BIT] = pin_s2_r[1];
    pin_word[`ACP_CODING_BIT] = pin_s2_r[0];
  end

  assign sw_mode = ser_s & ~hw_s;

  // Link side. The invert input is a strap; changing it mid-word
  // produces a spurious edge, so it must only move while deselected.
  logic link_clk;

  assign link_clk = config_serial_clock ^ serial_clock_invert;

  acp_word_if word_if ();

  // Runs on in power-down and in any read-out mode
  acp_shift u_shift (
    .link_clk(link_clk),
    .rst_n(rst_n_r),
    .config_port_select_n(config_port_select_n),
    .config_serial_data_in(config_serial_data_in),
    .out_if(word_if)
  );

  // Completion toggle crossing
  logic tgl_s1_r;
  logic tgl_s2_r;
  logic tgl_d_r;
  logic word_done;

  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      tgl_s1_r <= 1'b0;
      tgl_s2_r <= 1'b0;
      tgl_d_r <= 1'b0;
    end else begin
      tgl_s1_r <= word_if.done_tgl;
      tgl_s2_r <= tgl_s1_r;
      tgl_d_r <= tgl_s2_r;
    end
  end

  // Word is stable for at least eight link edges after the toggle
  assign word_done = tgl_s2_r ^ tgl_d_r;

  // Serial configuration register
  acp_word_t cfg_r;
  acp_word_t cfg_nxt;

  always_comb begin
    cfg_nxt = cfg_r;
    if (word_done && sw_mode) begin
      cfg_nxt[`ACP_START_BIT:`ACP_CODING_BIT] =
        word_if.word[`ACP_START_BIT:`ACP_CODING_BIT];
    end
  end

  // No power-up value is trusted; reset defines it
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      cfg_r <= `ACP_CFG_RESET;
    end else begin
      cfg_r <= cfg_nxt;
    end
  end

  // Active setting source
  acp_word_t active_r;
  acp_word_t active_nxt;
  logic active_chg;

  always_comb begin
    if (sw_mode) begin
      active_nxt = cfg_r;
    end else begin
      active_nxt = pin_word;
    end
    active_nxt[`ACP_START_BIT] = 1'b0;
    active_nxt[`ACP_RSV_MSB:0] = 2'b00;
  end

  assign active_chg = (active_nxt != active_r);

  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      active_r <= `ACP_CFG_RESET;
    end else begin
      active_r <= active_nxt;
    end
  end

  // Settling window after any applied change
  logic [CNT_W-1:0] settle_r;

  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      settle_r <= '0;
    end else if (active_chg || (word_done && sw_mode)) begin
      settle_r <= CNT_W'(ACQ_CYCLES);
    end else if (settle_r != '0) begin
      settle_r <= settle_r - CNT_W'(1);
    end
  end

  assign config_settling = (settle_r != '0);

  // Decoded settings
  acp_range_e range_nxt;
  acp_mode_e mode_nxt;

  always_comb begin
    case ({active_r[`ACP_BIPOLAR_BIT], active_r[`ACP_TEN_BIT]})
      2'b00: range_nxt = ACP_RANGE_0_5;
      2'b01: range_nxt = ACP_RANGE_0_10;
      2'b10: range_nxt = ACP_RANGE_PM5;
      default: range_nxt = ACP_RANGE_PM10;
    endcase
  end

  always_comb begin
    case ({active_r[`ACP_IMPULSE_BIT], active_r[`ACP_WARP_BIT]})
      2'b10: mode_nxt = ACP_MODE_IMPULSE;
      2'b01: mode_nxt = ACP_MODE_WARP;
      default: mode_nxt = ACP_MODE_NORMAL;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      range_select <= ACP_RANGE_0_5;
      conv_mode <= ACP_MODE_NORMAL;
    end else begin
      range_select <= range_nxt;
      conv_mode <= mode_nxt;
    end
  end

  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      converter_powered_down <= 1'b0;
      straight_binary <= 1'b0;
    end else begin
      converter_powered_down <= active_r[`ACP_PD_BIT];
      straight_binary <= active_r[`ACP_CODING_BIT];
    end
  end

  // Status outputs
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      software_config <= 1'b0;
      config_port_enable <= 1'b0;
      config_word <= `ACP_CFG_RESET;
      config_update <= 1'b0;
    end else begin
      software_config <= sw_mode;
      config_port_enable <= sw_mode;
      config_word <= cfg_r;
      config_update <= word_done & sw_mode;
    end
  end

endmodule // acp_config_port
`default_nettype wire

//--- logic/acp_shift.sv
// Serial configuration shift register on the port's own clock
`timescale 1ns/1ns
`default_nettype none
`include "acp_params.svh"
module acp_shift (
  input wire logic link_clk,
  input wire logic rst_n,
  input wire logic config_port_select_n,
  input wire logic config_serial_data_in,
  acp_word_if.src out_if
);
  import acp_pkg::*;

  acp_shift_e state_r;
  logic [2:0] cnt_r;
  logic [6:0] shreg_r;
  logic seq_rst_n;

  // Deselect aborts a partial word and rearms for the start bit
  assign seq_rst_n = rst_n & ~config_port_select_n;

  always_ff @(posedge link_clk or negedge seq_rst_n) begin
    if (!seq_rst_n) begin
      state_r <= ACP_SHIFT_WAIT_START;
      cnt_r <= 3'h0;
      shreg_r <= 7'h00;
    end else begin
      case (state_r)
        ACP_SHIFT_WAIT_START: begin
          if (config_serial_data_in) begin
            state_r <= ACP_SHIFT_LOAD;
            cnt_r <= 3'h0;
          end
        end
        ACP_SHIFT_LOAD: begin
          shreg_r <= {shreg_r[5:0], config_serial_data_in};
          cnt_r <= cnt_r + 3'h1;
          if (cnt_r == 3'(`ACP_LOAD_BITS - 1)) begin
            state_r <= ACP_SHIFT_WAIT_START;
          end
        end
        default: state_r <= ACP_SHIFT_WAIT_START;
      endcase
    end
  end

  // Word and toggle survive deselect so the core can still sample them
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_if.word <= `ACP_CFG_RESET;
      out_if.done_tgl <= 1'b0;
    end else if (seq_rst_n && state_r == ACP_SHIFT_LOAD &&
                 cnt_r == 3'(`ACP_LOAD_BITS - 1)) begin
      out_if.word <= {1'b1, shreg_r[6:0], config_serial_data_in};
      out_if.done_tgl <= ~out_if.done_tgl;
    end
  end

endmodule // acp_shift
`default_nettype wire
